// ---- hdl/mul_div_consts.svh ----
// Purpose: constants shared by the multiply/divide unit and its core-side driver
// Assumes: byte-wide internal data bus, register index 0..6
// Notes: index 6 is the status register
`ifndef MUL_DIV_CONSTS_SVH
`define MUL_DIV_CONSTS_SVH

`define MULDIV_IDX_STATUS 3'h6
`define MULDIV_IDX_LAST 3'h5
`define MULDIV_ERR_BIT 7
`define MULDIV_OVF_BIT 6
`define MULDIV_CYC_DIV32 5'h11
`define MULDIV_CYC_DIV16 5'h09
`define MULDIV_CYC_MUL 5'h0B

`endif

// ---- hdl/mul_div_pkg.sv ----
// Purpose: types for the multiply/divide unit
// Assumes: nothing
// Notes: none
`default_nettype none
package mul_div_pkg;
   typedef enum logic [1:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL} op_type;
   typedef logic [2:0] reg_idx_type;
   typedef logic [7:0] byte_type;
endpackage
`default_nettype wire

// ---- hdl/mul_div_if.sv ----
// Purpose: byte-wide register access between core and multiply/divide unit
// Assumes: one clock, accesses are single-cycle strobes
// Notes: read data valid in the cycle after a read strobe
`timescale 1ns/100ps
`default_nettype none
interface mul_div_if;
   logic wr;
   logic rd;
   logic [2:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic busy;
   modport unit (input wr, input rd, input idx, input wdata, output rdata, output busy);
   modport core (output wr, output rd, output idx, output wdata, input rdata, input busy);
endinterface
`default_nettype wire

// ---- hdl/mul_div_core_side.sv ----
// Purpose: core-side sequencer that loads operands, waits, checks status, reads results
// Assumes: unit answers reads one cycle after the strobe
// Notes: one access per operation step, never touches data bytes while busy
`timescale 1ns/100ps
`default_nettype none
`include "mul_div_consts.svh"
module mul_div_core_side (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire mul_div_pkg::op_type i_op,
   input wire logic [31:0] i_a,
   input wire logic [15:0] i_b,
   output logic o_done,
   output logic [31:0] o_result,
   output logic [15:0] o_rem,
   output logic o_overflow,
   output logic o_error,
   output logic o_idle,
   mul_div_if.core bus
);
   import mul_div_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_WRITE, S_WAIT, S_STAT, S_READ, S_LAST} st_type;
   st_type st_reg;
   op_type op_reg;
   logic [2:0] step_reg;
   logic [31:0] a_reg;
   logic [15:0] b_reg;
   logic pend_reg;
   logic [2:0] pidx_reg;

   // write order per operation, low byte before high byte
   function automatic logic [2:0] wr_idx(input op_type op, input logic [2:0] s);
      case (op)
         OP_DIV32: wr_idx = s;
         OP_DIV16: wr_idx = (s < 3'h2) ? s : s + 3'h2;
         OP_MUL: wr_idx = (s == 3'h1) ? 3'h4 : (s == 3'h2) ? 3'h1 : (s == 3'h3) ? 3'h5 : 3'h0;
         default: wr_idx = 3'h0;
      endcase
   endfunction
   function automatic logic [7:0] wr_byte(input logic [31:0] a, input logic [15:0] b, input logic [2:0] i);
      case (i)
         3'h0: wr_byte = a[7:0];
         3'h1: wr_byte = a[15:8];
         3'h2: wr_byte = a[23:16];
         3'h3: wr_byte = a[31:24];
         3'h4: wr_byte = b[7:0];
         default: wr_byte = b[15:8];
      endcase
   endfunction
   // result read order per operation
   function automatic logic [2:0] rd_idx(input op_type op, input logic [2:0] s);
      if (op == OP_DIV16) begin
         rd_idx = (s < 3'h2) ? s : s + 3'h2;
      end else begin
         rd_idx = s;
      end
   endfunction
   function automatic logic [2:0] n_bytes(input op_type op);
      n_bytes = (op == OP_DIV32) ? 3'h6 : 3'h4;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_reg <= S_IDLE;
         op_reg <= OP_NONE;
         step_reg <= 3'h0;
         a_reg <= 32'h0;
         b_reg <= 16'h0;
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         bus.idx <= 3'h0;
         bus.wdata <= 8'h0;
         pend_reg <= 1'b0;
         pidx_reg <= 3'h0;
         o_done <= 1'b0;
         o_result <= 32'h0;
         o_rem <= 16'h0;
         o_overflow <= 1'b0;
         o_error <= 1'b0;
         o_idle <= 1'b1;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         o_done <= 1'b0;
         pend_reg <= bus.rd;
         pidx_reg <= bus.idx;
         if (pend_reg) begin
            if (pidx_reg == `MULDIV_IDX_STATUS) begin
               o_error <= bus.rdata[`MULDIV_ERR_BIT];
               o_overflow <= bus.rdata[`MULDIV_OVF_BIT];
            end else if (pidx_reg < 3'h4) begin
               o_result[{pidx_reg[1:0], 3'h0} +: 8] <= bus.rdata;
            end else begin
               o_rem[{pidx_reg[0], 3'h0} +: 8] <= bus.rdata;
            end
         end
         case (st_reg)
            S_IDLE: begin
               o_idle <= 1'b1;
               if (i_start && i_op != OP_NONE) begin
                  op_reg <= i_op;
                  a_reg <= i_a;
                  b_reg <= i_b;
                  step_reg <= 3'h0;
                  o_result <= 32'h0;
                  o_rem <= 16'h0;
                  o_idle <= 1'b0;
                  st_reg <= S_WRITE;
               end
            end
            S_WRITE: begin
               bus.wr <= 1'b1;
               bus.idx <= wr_idx(op_reg, step_reg);
               bus.wdata <= wr_byte(a_reg, b_reg, wr_idx(op_reg, step_reg));
               step_reg <= step_reg + 3'h1;
               if (step_reg == n_bytes(op_reg) - 3'h1) begin
                  st_reg <= S_WAIT;
               end
            end
            S_WAIT: begin
               // hold off every data access until the unit drops busy
               if (!bus.busy && !bus.wr) begin
                  st_reg <= S_STAT;
               end
            end
            S_STAT: begin
               bus.rd <= 1'b1;
               bus.idx <= `MULDIV_IDX_STATUS;
               step_reg <= 3'h0;
               st_reg <= S_READ;
            end
            S_READ: begin
               bus.rd <= 1'b1;
               bus.idx <= rd_idx(op_reg, step_reg);
               step_reg <= step_reg + 3'h1;
               if (step_reg == n_bytes(op_reg) - 3'h1) begin
                  st_reg <= S_LAST;
               end
            end
            S_LAST: begin
               if (!pend_reg && !bus.rd) begin
                  o_done <= 1'b1;
                  st_reg <= S_IDLE;
               end
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- hdl/mul_div_unit.sv ----
// Purpose: multiply/divide unit started by the write order of four or six operand bytes
// Assumes: core issues one-cycle read/write strobes; read data follows one cycle later
// Notes: result appears after a fixed latency per operation; index 6 is status
// a wrong write order stores the bytes but starts nothing
// busy reads of data bytes answer zero and raise the error flag
//
// Behaviour
// - operand low byte written before high byte
// - start only on write 5 completing order
// - gaps between writes keep order tracking
// - writes 0..5 start 32/16 division
// - writes 0,1,4,5 start 16/16 division
// - writes 0,4,1,5 start 16x16 multiply
// - latency 17, 9, 11 clocks
// - no operand access while calculating
// - software checks status before reading results
// - results replace operands in same registers
// - 32/16 results read 0..3 then 4,5
// - 16/16 results read 0,1 then 4,5
// - product read 0..3, low first
// - gaps between result reads tolerated
// - no sleep until operation complete
// - error flag on busy access, status read while not busy clears
// - overflow on product above FFFF or zero divisor
// - multiply operands unsigned
`timescale 1ns/100ps
`default_nettype none
`include "mul_div_consts.svh"
module mul_div_unit (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   output logic o_busy,
   output logic o_result_ready,
   mul_div_if.unit bus
);
   import mul_div_pkg::*;
   logic [7:0] data_reg [0:5];
   logic [7:0] seq_reg;
   op_type op_reg;
   logic [4:0] cnt_reg;
   logic err_reg;
   logic ovf_reg;
   logic [7:0] rdata_reg;
   logic [31:0] dvd;
   logic [15:0] dvs;
   logic [31:0] quo;
   logic [15:0] rem;
   logic [31:0] prod;
   op_type start_op;
   logic op_end;
   logic data_wr;

   // one-hot write-order history; only operand writes advance it
   // a write that fits no legal order drops the history, so a stray
   // byte can never let a later write 5 start on stale operands
   function automatic logic [7:0] track(input logic [7:0] s, input logic [2:0] i);
      case (i)
         3'h0: track = 8'h01;
         3'h1: track = (s == 8'h01) ? 8'h02 : (s == 8'h04) ? 8'h08 : 8'h00;
         3'h2: track = (s == 8'h02) ? 8'h10 : 8'h00;
         3'h3: track = (s == 8'h10) ? 8'h20 : 8'h00;
         3'h4: track = (s == 8'h01) ? 8'h04 : (s == 8'h02) ? 8'h40 : (s == 8'h20) ? 8'h80 : 8'h00;
         default: track = 8'h00;
      endcase
   endfunction

   // operand and result bytes sit at indices 0..5; 6 is status, 7 is a hole
   function automatic logic is_data(input logic [2:0] i);
      is_data = (i <= `MULDIV_IDX_LAST);
   endfunction

   // all operands unsigned, byte 0 least significant
   // a zero divisor yields all ones and hands the low dividend half back as remainder
   assign dvd = (op_reg == OP_DIV32) ? {data_reg[3], data_reg[2], data_reg[1], data_reg[0]}
                                     : {16'h0, data_reg[1], data_reg[0]};
   assign dvs = {data_reg[5], data_reg[4]};
   assign quo = (dvs == 16'h0) ? 32'hFFFFFFFF : dvd / {16'h0, dvs};
   assign rem = (dvs == 16'h0) ? dvd[15:0] : 16'((dvd % {16'h0, dvs}));
   assign prod = {16'h0, data_reg[1], data_reg[0]} * {16'h0, dvs};

   // history states:
   //   01 = w0
   //   02 = w0 w1
   //   04 = w0 w4
   //   08 = w0 w4 w1, multiply armed
   //   10 = w0 w1 w2
   //   20 = w0 w1 w2 w3
   //   40 = w0 w1 w4, short division armed
   //   80 = w0 w1 w2 w3 w4, long division armed
   always_comb begin
      start_op = OP_NONE;
      if (bus.wr && bus.idx == `MULDIV_IDX_LAST && !o_busy) begin
         case (seq_reg)
            8'h80: start_op = OP_DIV32;
            8'h40: start_op = OP_DIV16;
            8'h08: start_op = OP_MUL;
            default: start_op = OP_NONE;
         endcase
      end
   end

   // last calculating cycle: results and overflow are committed here
   assign op_end = o_busy && (cnt_reg == 5'h01);
   // operand writes while busy are dropped, never stored
   assign data_wr = bus.wr && !o_busy && is_data(bus.idx);

   ////////////////////////////////////////////////////////////////////////////
   // write order tracking; reads and idle cycles leave it alone
   // tracking pauses while busy, since those writes are refused
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         seq_reg <= 8'h00;
      end else if (data_wr) begin
         seq_reg <= track(seq_reg, bus.idx);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calculation sequencing
   // counter loads the full latency and busy drops as it steps from one to zero
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_busy <= 1'b0;
         o_result_ready <= 1'b0;
         op_reg <= OP_NONE;
         cnt_reg <= 5'h0;
      end else begin
         o_result_ready <= 1'b0;
         if (start_op != OP_NONE) begin
            o_busy <= 1'b1;
            op_reg <= start_op;
            case (start_op)
               OP_DIV32: cnt_reg <= `MULDIV_CYC_DIV32;
               OP_DIV16: cnt_reg <= `MULDIV_CYC_DIV16;
               default: cnt_reg <= `MULDIV_CYC_MUL;
            endcase
         end else if (o_busy) begin
            cnt_reg <= cnt_reg - 5'h1;
            if (cnt_reg == 5'h1) begin
               o_busy <= 1'b0;
               o_result_ready <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand/result storage
   // results replace operands in place; a product leaves the multiplier in 4/5
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         for (int i = 0; i < 6; i++) begin
            data_reg[i] <= 8'h00;
         end
      end else if (op_end) begin
         if (op_reg == OP_MUL) begin
            {data_reg[3], data_reg[2], data_reg[1], data_reg[0]} <= prod;
         end else begin
            {data_reg[3], data_reg[2], data_reg[1], data_reg[0]} <= quo;
            {data_reg[5], data_reg[4]} <= rem;
         end
      end else if (data_wr) begin
         // write during calculation is dropped so operands stay intact
         data_reg[bus.idx] <= bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         err_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else begin
         // set wins over the clearing status read
         if (o_busy && (bus.wr || bus.rd) && is_data(bus.idx)) begin
            err_reg <= 1'b1;
         end else if (bus.rd && bus.idx == `MULDIV_IDX_STATUS && !o_busy) begin
            err_reg <= 1'b0;
         end
         // overflow is refreshed at each completion; reads leave it alone
         if (op_end) begin
            ovf_reg <= (op_reg == OP_MUL) ? (prod[31:16] != 16'h0) : (dvs == 16'h0);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port; any result byte may be read at any time after completion
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         rdata_reg <= 8'h00;
      end else if (bus.rd) begin
         // a data read while busy answers zero, never a half-built result
         if (bus.idx == `MULDIV_IDX_STATUS) begin
            rdata_reg <= {err_reg, ovf_reg, 6'h00};
         end else if (is_data(bus.idx) && !o_busy) begin
            rdata_reg <= data_reg[bus.idx];
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end

   assign bus.rdata = rdata_reg;
   assign bus.busy = o_busy;
endmodule
`default_nettype wire

// ---- verif/mul_div_unit_asserts.sv ----
// Purpose: bus-level checks on the multiply/divide unit
// Assumes: one clock, synchronous active-low reset
// Notes: write order itself is judged by the bench
`timescale 1ns/100ps
`default_nettype none
module mul_div_unit_asserts (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic wr,
   input wire logic rd,
   input wire logic [2:0] idx,
   input wire logic [7:0] rdata,
   input wire logic busy
);
   logic err_reg;
   logic [4:0] cnt_reg;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   ////////////////////////////////////////
   // set wins over clear, as the unit resolves it
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst)
         err_reg <= 1'b0;
      else if (busy && (wr || rd) && idx < 3'h6)
         err_reg <= 1'b1;
      else if (rd && idx == 3'h6 && !busy)
         err_reg <= 1'b0;
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst || !busy)
         cnt_reg <= 5'h00;
      else
         cnt_reg <= cnt_reg + 5'h01;
   end
   sequence busy_run;
      busy [*8];
   endsequence
   start_on_write_a: assert property ($rose(busy) |-> $past(wr) && $past(idx) == 3'h5) else $error("start without write 5");
   busy_length_a: assert property ($fell(busy) |-> cnt_reg == 5'h11 || cnt_reg == 5'h09 || cnt_reg == 5'h0B)
      else $error("busy length wrong");
   min_busy_a: assert property ($rose(busy) |-> busy_run) else $error("busy too short");
   busy_read_zero_a: assert property (rd && busy && idx < 3'h6 |=> rdata == 8'h00) else $error("busy read not zero");
   status_err_a: assert property (rd && idx == 3'h6 |=> rdata[7] == $past(err_reg)) else $error("error flag wrong");
   status_pad_a: assert property (rd && idx == 3'h6 |=> rdata[5:0] == 6'h00) else $error("status pad bits set");
   unmapped_read_a: assert property (rd && idx == 3'h7 |=> rdata == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("read data moved");
endmodule
`default_nettype wire

// ---- verif/multiply_divide_unit_tb_top.sv ----
// Purpose: bench for the unit joined to its core-side sequencer
// Assumes: 200 MHz clock, inputs driven on falling edge
// Notes: a second unit is driven raw to break access rules
`timescale 1ns/100ps
`default_nettype none
module multiply_divide_unit_tb_top;
   import mul_div_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_start = 1'b0;
   op_type i_op = OP_NONE;
   logic [31:0] i_a = 32'h00000000;
   logic [15:0] i_b = 16'h0000;
   logic o_done, o_overflow, o_error, o_idle, o_busy, o_result_ready;
   logic [31:0] o_result;
   logic [15:0] o_rem;
   int n_fail = 0;
   int num_checks = 0;
   mul_div_if u_mul_div_if ();
   mul_div_if u_mul_div_if_raw ();
   mul_div_core_side u_mul_div_core_side (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(i_start), .i_op(i_op),
      .i_a(i_a), .i_b(i_b), .o_done(o_done), .o_result(o_result), .o_rem(o_rem), .o_overflow(o_overflow),
      .o_error(o_error), .o_idle(o_idle), .bus(u_mul_div_if));
   mul_div_unit u_mul_div_unit (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_busy(o_busy), .o_result_ready(o_result_ready),
      .bus(u_mul_div_if));
   mul_div_unit u_mul_div_unit_raw (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_busy(), .o_result_ready(),
      .bus(u_mul_div_if_raw));
   mul_div_unit_asserts u_mul_div_unit_asserts (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .wr(u_mul_div_if.wr),
      .rd(u_mul_div_if.rd), .idx(u_mul_div_if.idx), .rdata(u_mul_div_if.rdata), .busy(u_mul_div_if.busy));
   always #2.5 i_sys_clk = ~i_sys_clk;
   ////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // expectation built from the operands, never from the unit
   task automatic run_op(input op_type op, input logic [31:0] a, input logic [15:0] b);
      logic [31:0] d, q, r;
      int n, nr, t, cyc;
      n = 0;
      nr = 0;
      cyc = (op == OP_DIV32) ? 17 : (op == OP_DIV16) ? 9 : 11;
      d = (op == OP_DIV32) ? a : {16'h0000, a[15:0]};
      q = (op == OP_MUL) ? d * {16'h0000, b} : (b == 16'h0000) ? 32'hFFFFFFFF : d / {16'h0000, b};
      r = (b == 16'h0000) ? {16'h0000, d[15:0]} : d % {16'h0000, b};
      @(negedge i_sys_clk);
      check(o_idle === 1'b1, "not idle");
      i_op = op;
      i_a = a;
      i_b = b;
      i_start = 1'b1;
      @(negedge i_sys_clk);
      i_start = 1'b0;
      for (t = 0; t < 200 && o_done !== 1'b1; t++) begin
         @(negedge i_sys_clk);
         if (o_busy === 1'b1)
            n++;
         if (o_result_ready === 1'b1)
            nr++;
      end
      check(n == cyc, "busy cycles");
      check(nr == 1, "result ready pulse");
      check(o_result === q, "quotient or product");
      check(op == OP_MUL || o_rem === r[15:0], "remainder");
      check(o_overflow === (op == OP_MUL ? q > 32'h0000FFFF : b == 16'h0000), "overflow");
      check(o_error === 1'b0, "error flag");
   endtask
   task automatic bw(input logic [2:0] i, input logic [7:0] d);
      @(negedge i_sys_clk);
      u_mul_div_if_raw.wr = 1'b1;
      u_mul_div_if_raw.idx = i;
      u_mul_div_if_raw.wdata = d;
      @(negedge i_sys_clk);
      u_mul_div_if_raw.wr = 1'b0;
   endtask
   task automatic br(input logic [2:0] i, output logic [7:0] d);
      @(negedge i_sys_clk);
      u_mul_div_if_raw.rd = 1'b1;
      u_mul_div_if_raw.idx = i;
      @(negedge i_sys_clk);
      u_mul_div_if_raw.rd = 1'b0;
      d = u_mul_div_if_raw.rdata;
   endtask
   // wrong order, gaps, busy access, status clear, spaced reads
   task automatic raw_rules();
      logic [7:0] s;
      logic [31:0] p;
      int t;
      p = 32'h00001234 * 32'h00005678;
      bw(3'h0, 8'h11);
      bw(3'h1, 8'h22);
      bw(3'h5, 8'h33);
      repeat (3) @(negedge i_sys_clk);
      check(u_mul_div_if_raw.busy === 1'b0, "start on bad order");
      bw(3'h0, 8'h34);
      br(3'h6, s);
      bw(3'h4, 8'h78);
      repeat (3) @(negedge i_sys_clk);
      bw(3'h1, 8'h12);
      bw(3'h5, 8'h56);
      check(u_mul_div_if_raw.busy === 1'b1, "no start after gaps");
      br(3'h0, s);
      check(s === 8'h00, "busy read data");
      for (t = 0; t < 30 && u_mul_div_if_raw.busy !== 1'b0; t++)
         @(negedge i_sys_clk);
      br(3'h6, s);
      check(s[7:6] === 2'b11, "status after busy access");
      br(3'h6, s);
      check(s[7] === 1'b0, "error not cleared");
      for (t = 0; t < 4; t++) begin
         br(3'(t), s);
         check(s === p[8 * t +: 8], "product byte");
         @(negedge i_sys_clk);
      end
   endtask
   initial begin
      u_mul_div_if_raw.wr = 1'b0;
      u_mul_div_if_raw.rd = 1'b0;
      u_mul_div_if_raw.idx = 3'h0;
      u_mul_div_if_raw.wdata = 8'h00;
      repeat (3) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      run_op(OP_DIV32, 32'h87654321, 16'h0123);
      run_op(OP_DIV32, 32'hFFFFFFFF, 16'hFFFF);
      run_op(OP_DIV32, 32'h0000A5C3, 16'h0000);
      run_op(OP_DIV16, 32'hDEADBEEF, 16'h0011);
      run_op(OP_MUL, 32'h0000FFFF, 16'hFFFF);
      run_op(OP_MUL, 32'h00000012, 16'h0034);
      raw_rules();
      complete_run();
   end
   initial begin
      #50000;
      n_fail++;
      complete_run();
   end
endmodule
`default_nettype wire
